// *** core/scr_pkg.sv ***
// constants and carrier types of the switch capability register bank
// ****************************************************************
// Behaviour
// - bits 22 and 23 of dword 44h read zero and never take writes
// - bits 31:24 of dword 44h hold a read-only power data byte, reset zero
// - message capability header low byte reads the fixed identifier 05h
// - message capability next pointer in bits 15:8 reads 64h
// - message enable bit 16 writable, resets zero, selects message or legacy signalling
// - bit 23 reads one: a 64-bit message address can be produced
// - address bits 31:2 writable, bits 1:0 reserved, resets zero
// - writable 32-bit upper address, used only with 64-bit addressing support
// - vendor capability header low byte reads fixed identifier 09h
// - vendor capability next pointer reads B0h
// - bits 31:16 of vendor header report structure length 0034h
// - writable test scratch register at 68h, resets to 0400_1060h
// - writable test scratch register at 6Ch, resets to 0000_0800h
// - writable 12-bit user replay timeout in bits 11:0, resets zero
// - bit 12 set selects the user replay timeout over the built-in one
// - writable 14-bit user acknowledge latency in bits 29:16, resets zero
// - bit 30 set selects the user acknowledge latency over the built-in one
// - bit 31 of dword 70h reads one: range decoding enabled
// - management bus or autoload may replace configurable defaults after reset
// ****************************************************************
package scr_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_PM_EXT = 8'h44;
    localparam logic [7:0] OFS_MSG_CAP = 8'h4C;
    localparam logic [7:0] OFS_MSG_ADDR_LO = 8'h50;
    localparam logic [7:0] OFS_MSG_ADDR_HI = 8'h54;
    localparam logic [7:0] OFS_MSG_DATA = 8'h58;
    localparam logic [7:0] OFS_VENDOR_CAP = 8'h64;
    localparam logic [7:0] OFS_SCRATCH0 = 8'h68;
    localparam logic [7:0] OFS_SCRATCH1 = 8'h6C;
    localparam logic [7:0] OFS_TIMERS = 8'h70;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int POS_BUS_PWR_SUPPORT = 22;
    localparam int POS_BUS_CLK_CTRL = 23;
    localparam int POS_PWR_DATA = 24;
    localparam int POS_CAP_NEXT = 8;
    localparam int POS_MSG_EN = 16;
    localparam int POS_MM_CAPABLE = 17;
    localparam int POS_MM_ENABLE = 20;
    localparam int POS_ADDR64 = 23;
    localparam int POS_ADDR_LO = 2;
    localparam int POS_VENDOR_LEN = 16;
    localparam int POS_REPLAY_EN = 12;
    localparam int POS_PM_CAP_DIS = 13;
    localparam int POS_MSG_CAP_DIS = 14;
    localparam int POS_ACK_LAT = 16;
    localparam int POS_ACK_LAT_EN = 30;
    localparam int POS_RANGE_DECODE = 31;

    // ****************************************************************
    // fixed values and reset values
    // ****************************************************************
    localparam logic [7:0] MSG_CAP_ID = 8'h05;
    localparam logic [7:0] MSG_CAP_NEXT = 8'h64;
    localparam logic [2:0] MM_CAPABLE_VAL = 3'h2;
    localparam logic ADDR64_VAL = 1'b1;
    localparam logic [7:0] VENDOR_CAP_ID = 8'h09;
    localparam logic [7:0] VENDOR_CAP_NEXT = 8'hB0;
    localparam logic [15:0] VENDOR_CAP_LEN = 16'h0034;
    localparam logic RANGE_DECODE_VAL = 1'b1;
    localparam logic [7:0] RST_PWR_DATA = 8'h00;
    localparam logic [31:0] RST_SCRATCH0 = 32'h04001060;
    localparam logic [31:0] RST_SCRATCH1 = 32'h00000800;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } scr_cfg_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } scr_cfg_rsp_s;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } scr_load_req_s;

    typedef struct packed {
        logic valid;
        logic [63:0] addr;
        logic [15:0] data;
    } scr_msg_wr_s;

    typedef struct packed {
        logic [7:0] pwr_data;
        logic msg_en;
        logic [2:0] mm_enable;
        logic [29:0] addr_lo;
        logic [31:0] addr_hi;
        logic [15:0] msg_data;
        logic [31:0] scratch0;
        logic [31:0] scratch1;
        logic [11:0] replay_val;
        logic replay_en;
        logic pm_cap_dis;
        logic msg_cap_dis;
        logic [13:0] ack_lat_val;
        logic ack_lat_en;
        logic pending;
        scr_msg_wr_s msg_wr;
        logic legacy_irq;
        scr_cfg_rsp_s rsp;
    } scr_state_s;

endpackage : scr_pkg

// *** core/scr_cfg_regs.sv ***
// configuration register bank with message interrupt and timer overrides
module scr_cfg_regs #(
    parameter logic [11:0] BUILTIN_REPLAY = 12'h100,
    parameter logic [13:0] BUILTIN_ACK_LAT = 14'h0040
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire scr_pkg::scr_cfg_req_s cfg_req_in,
    output scr_pkg::scr_cfg_rsp_s cfg_rsp_out,
    input wire scr_pkg::scr_load_req_s load_req_in,
    input wire logic irq_event_in,
    output scr_pkg::scr_msg_wr_s msg_wr_out,
    input wire logic msg_wr_ready_in,
    output logic legacy_irq_out,
    output logic [11:0] replay_timeout_out,
    output logic [13:0] ack_latency_out,
    output logic range_decode_en_out,
    output logic pm_cap_disable_out,
    output logic msg_cap_disable_out
);
    import scr_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    scr_state_s st;
    scr_state_s next_st;
    logic [31:0] cfg_mask;
    logic [31:0] load_mask;

    // ****************************************************************
    // byte enables widened to bit masks
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            assign cfg_mask[gi*8 +: 8] = {8{cfg_req_in.be[gi]}};
            assign load_mask[gi*8 +: 8] = {8{load_req_in.be[gi]}};
        end
    endgenerate

    // ****************************************************************
    // read view of one dword; reserved bits come back zero
    // ****************************************************************
    function automatic logic [31:0] read_word(input logic [7:0] addr, input scr_state_s s);
        logic [31:0] w;
        w = RST_WORD;
        unique case (addr)
            OFS_PM_EXT: begin
                w[POS_BUS_PWR_SUPPORT] = 1'b0;
                w[POS_BUS_CLK_CTRL] = 1'b0;
                w[POS_PWR_DATA +: 8] = s.pwr_data;
            end
            OFS_MSG_CAP: begin
                w[7:0] = MSG_CAP_ID;
                w[POS_CAP_NEXT +: 8] = MSG_CAP_NEXT;
                w[POS_MSG_EN] = s.msg_en;
                w[POS_MM_CAPABLE +: 3] = MM_CAPABLE_VAL;
                w[POS_MM_ENABLE +: 3] = s.mm_enable;
                w[POS_ADDR64] = ADDR64_VAL;
            end
            OFS_MSG_ADDR_LO: begin
                w[POS_ADDR_LO +: 30] = s.addr_lo;
            end
            OFS_MSG_ADDR_HI: begin
                w = s.addr_hi;
            end
            OFS_MSG_DATA: begin
                w[15:0] = s.msg_data;
            end
            OFS_VENDOR_CAP: begin
                w[7:0] = VENDOR_CAP_ID;
                w[POS_CAP_NEXT +: 8] = VENDOR_CAP_NEXT;
                w[POS_VENDOR_LEN +: 16] = VENDOR_CAP_LEN;
            end
            OFS_SCRATCH0: begin
                w = s.scratch0;
            end
            OFS_SCRATCH1: begin
                w = s.scratch1;
            end
            OFS_TIMERS: begin
                w[11:0] = s.replay_val;
                w[POS_REPLAY_EN] = s.replay_en;
                w[POS_PM_CAP_DIS] = s.pm_cap_dis;
                w[POS_MSG_CAP_DIS] = s.msg_cap_dis;
                w[POS_ACK_LAT +: 14] = s.ack_lat_val;
                w[POS_ACK_LAT_EN] = s.ack_lat_en;
                w[POS_RANGE_DECODE] = RANGE_DECODE_VAL;
            end
            default: begin
                w = RST_WORD;
            end
        endcase
        return w;
    endfunction

    // ****************************************************************
    // configuration write: only read-write fields take the merged value
    // ****************************************************************
    function automatic scr_state_s cfg_write(input logic [7:0] addr, input logic [31:0] m,
                                             input scr_state_s s);
        scr_state_s r;
        r = s;
        unique case (addr)
            OFS_MSG_CAP: begin
                r.msg_en = m[POS_MSG_EN];
                r.mm_enable = m[POS_MM_ENABLE +: 3];
            end
            OFS_MSG_ADDR_LO: begin
                r.addr_lo = m[POS_ADDR_LO +: 30];
            end
            OFS_MSG_ADDR_HI: begin
                r.addr_hi = m;
            end
            OFS_MSG_DATA: begin
                r.msg_data = m[15:0];
            end
            OFS_SCRATCH0: begin
                r.scratch0 = m;
            end
            OFS_SCRATCH1: begin
                r.scratch1 = m;
            end
            OFS_TIMERS: begin
                r.replay_val = m[11:0];
                r.replay_en = m[POS_REPLAY_EN];
                r.ack_lat_val = m[POS_ACK_LAT +: 14];
                r.ack_lat_en = m[POS_ACK_LAT_EN];
            end
            default: begin
                r = s;
            end
        endcase
        return r;
    endfunction

    // ****************************************************************
    // default loader: may also replace loadable read-only fields
    // ****************************************************************
    function automatic scr_state_s load_write(input logic [7:0] addr, input logic [31:0] m,
                                              input scr_state_s s);
        scr_state_s r;
        r = cfg_write(addr, m, s);
        unique case (addr)
            OFS_PM_EXT: begin
                r.pwr_data = m[POS_PWR_DATA +: 8];
            end
            OFS_TIMERS: begin
                r.pm_cap_dis = m[POS_PM_CAP_DIS];
                r.msg_cap_dis = m[POS_MSG_CAP_DIS];
            end
            default: begin
                r.pwr_data = s.pwr_data;
            end
        endcase
        return r;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [31:0] cur;
        logic [31:0] merged;
        logic [31:0] lcur;
        logic [31:0] lmerged;
        logic fire;
        cur = RST_WORD;
        merged = RST_WORD;
        lcur = RST_WORD;
        lmerged = RST_WORD;
        fire = 1'b0;
        next_st = st;

        // answer every request one cycle later
        next_st.rsp.ack = cfg_req_in.valid;
        next_st.rsp.rdata = st.rsp.rdata;
        if (cfg_req_in.valid) begin
            cur = read_word(cfg_req_in.addr, st);
            if (cfg_req_in.write) begin
                merged = (cur & ~cfg_mask) | (cfg_req_in.wdata & cfg_mask);
                next_st = cfg_write(cfg_req_in.addr, merged, next_st);
                next_st.rsp.rdata = RST_WORD;
            end else begin
                next_st.rsp.rdata = cur;
            end
        end

        // loader applied after the host write, so it wins a same-cycle clash
        if (load_req_in.valid) begin
            lcur = read_word(load_req_in.addr, next_st);
            lmerged = (lcur & ~load_mask) | (load_req_in.wdata & load_mask);
            next_st = load_write(load_req_in.addr, lmerged, next_st);
        end

        // interrupt delivery
        next_st.legacy_irq = 1'b0;
        if (st.msg_wr.valid && msg_wr_ready_in) begin
            next_st.msg_wr.valid = 1'b0;
        end
        if (!st.msg_en) begin
            // disabled: no message writes, events go out as legacy pulses
            next_st.pending = 1'b0;
            next_st.legacy_irq = irq_event_in;
        end else begin
            // new event sets pending even as the previous one drains
            fire = st.pending && (!st.msg_wr.valid || msg_wr_ready_in);
            next_st.pending = irq_event_in || (st.pending && !fire);
            if (fire) begin
                next_st.msg_wr.valid = 1'b1;
                next_st.msg_wr.addr[31:0] = {st.addr_lo, 2'b00};
                next_st.msg_wr.addr[63:32] = ADDR64_VAL ? st.addr_hi : RST_WORD;
                next_st.msg_wr.data = st.msg_data;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st <= '0;
            st.pwr_data <= RST_PWR_DATA;
            st.scratch0 <= RST_SCRATCH0;
            st.scratch1 <= RST_SCRATCH1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cfg_rsp_out = st.rsp;
    assign msg_wr_out = st.msg_wr;
    assign legacy_irq_out = st.legacy_irq;
    assign replay_timeout_out = st.replay_en ? st.replay_val : BUILTIN_REPLAY;
    assign ack_latency_out = st.ack_lat_en ? st.ack_lat_val : BUILTIN_ACK_LAT;
    assign range_decode_en_out = RANGE_DECODE_VAL;
    assign pm_cap_disable_out = st.pm_cap_dis;
    assign msg_cap_disable_out = st.msg_cap_dis;

endmodule // scr_cfg_regs

// *** dv/scr_cfg_props.sv ***
// assertions on the ports of the register bank
module scr_cfg_props
    import scr_pkg::*;
#(
    parameter logic [11:0] BUILTIN_REPLAY = 12'h100,
    parameter logic [13:0] BUILTIN_ACK_LAT = 14'h0040
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire scr_pkg::scr_cfg_req_s cfg_req_in,
    input wire scr_pkg::scr_cfg_rsp_s cfg_rsp_out,
    input wire scr_pkg::scr_load_req_s load_req_in,
    input wire logic irq_event_in,
    input wire scr_pkg::scr_msg_wr_s msg_wr_out,
    input wire logic msg_wr_ready_in,
    input wire logic legacy_irq_out,
    input wire logic [11:0] replay_timeout_out,
    input wire logic [13:0] ack_latency_out,
    input wire logic range_decode_en_out
);
    // ****************************************************************
    // sequences and properties
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rd(logic [7:0] a);
        cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == a;
    endsequence
    sequence s_wr;
        cfg_req_in.valid && cfg_req_in.write;
    endsequence
    property p_ack_follows;
        cfg_req_in.valid |=> cfg_rsp_out.ack;
    endproperty
    property p_wr_zero;
        s_wr |=> cfg_rsp_out.ack && cfg_rsp_out.rdata == 32'h00000000;
    endproperty
    property p_pm_read;
        s_rd(OFS_PM_EXT) |=> cfg_rsp_out.rdata[23:16] == 8'h00;
    endproperty
    property p_cap_read;
        s_rd(OFS_MSG_CAP) |=> cfg_rsp_out.rdata[15:0] == 16'h6405 && cfg_rsp_out.rdata[31:23] == 9'h001
            && cfg_rsp_out.rdata[19:17] == 3'h2;
    endproperty
    property p_vendor_read;
        s_rd(OFS_VENDOR_CAP) |=> cfg_rsp_out.rdata == 32'h0034B009;
    endproperty
    property p_lo_read;
        s_rd(OFS_MSG_ADDR_LO) |=> cfg_rsp_out.rdata[1:0] == 2'h0;
    endproperty
    property p_timer_sel;
        s_rd(OFS_TIMERS) ##0 !load_req_in.valid |=> cfg_rsp_out.rdata[31] && !cfg_rsp_out.rdata[15]
            && replay_timeout_out == (cfg_rsp_out.rdata[12] ? cfg_rsp_out.rdata[11:0] : BUILTIN_REPLAY)
            && ack_latency_out == (cfg_rsp_out.rdata[30] ? cfg_rsp_out.rdata[29:16] : BUILTIN_ACK_LAT);
    endproperty
    property p_msg_hold;
        msg_wr_out.valid && !msg_wr_ready_in |=> msg_wr_out.valid && $stable(msg_wr_out.addr)
            && $stable(msg_wr_out.data);
    endproperty
    property p_legacy;
        legacy_irq_out |-> $past(irq_event_in) && !msg_wr_out.valid;
    endproperty
    property p_range;
        range_decode_en_out == 1'b1;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request not acked");
    a_wr_zero: assert property (p_wr_zero) else $error("write ack data not zero");
    a_pm_read: assert property (p_pm_read) else $error("extension bits not zero");
    a_cap_read: assert property (p_cap_read) else $error("message header wrong");
    a_vendor_read: assert property (p_vendor_read) else $error("vendor header wrong");
    a_lo_read: assert property (p_lo_read) else $error("address low bits set");
    a_timer_sel: assert property (p_timer_sel) else $error("timer select wrong");
    a_msg_hold: assert property (p_msg_hold) else $error("message write dropped");
    a_legacy: assert property (p_legacy) else $error("legacy pulse without event");
    a_range: assert property (p_range) else $error("range decode low");
endmodule // scr_cfg_props

// *** dv/scr_msg_sink.sv ***
// message write sink standing for the upstream side
module scr_msg_sink
    import scr_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire scr_pkg::scr_msg_wr_s msg_wr_in,
    input wire logic [3:0] stall_in,
    output logic ready_out,
    output logic [7:0] taken_out
);
    logic [3:0] wait_cnt;
    // ****************************************************************
    // stall then accept
    // ****************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ready_out <= 1'b0;
            wait_cnt <= 4'h0;
            taken_out <= 8'h00;
        end else if (msg_wr_in.valid && !ready_out) begin
            ready_out <= (wait_cnt == stall_in);
            wait_cnt <= (wait_cnt == stall_in) ? 4'h0 : wait_cnt + 4'h1;
        end else begin
            ready_out <= 1'b0;
            wait_cnt <= 4'h0;
            taken_out <= taken_out + {7'h00, msg_wr_in.valid};
        end
    end
endmodule // scr_msg_sink

// *** dv/tb_top.sv ***
// self-checking bench of the switch capability register bank
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import scr_pkg::*;
    localparam logic [11:0] REPLAY_DEF = 12'h123;
    localparam logic [13:0] ACK_DEF = 14'h0456;
    typedef struct packed {logic [7:0] addr; logic [31:0] rst; logic [31:0] ones;} scr_row_s;
    scr_row_s rows [10] = '{'{8'h44, 32'h0, 32'h0}, '{8'h4C, 32'h00846405, 32'h00F56405},
        '{8'h50, 32'h0, 32'hFFFFFFFC}, '{8'h54, 32'h0, 32'hFFFFFFFF}, '{8'h58, 32'h0, 32'h0000FFFF},
        '{8'h64, 32'h0034B009, 32'h0034B009}, '{8'h68, 32'h04001060, 32'hFFFFFFFF},
        '{8'h6C, 32'h00000800, 32'hFFFFFFFF}, '{8'h70, 32'h80000000, 32'hFFFF1FFF}, '{8'h80, 32'h0, 32'h0}};
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    scr_cfg_req_s cfg_req = '0;
    scr_cfg_rsp_s cfg_rsp;
    scr_load_req_s load_req = '0;
    logic irq_event = 1'b0;
    scr_msg_wr_s msg_wr;
    logic msg_ready, legacy_irq, range_en, pm_dis, msg_dis;
    logic [11:0] replay_to;
    logic [13:0] ack_lat;
    logic [7:0] taken;
    logic [31:0] rd;
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    scr_cfg_regs #(.BUILTIN_REPLAY(REPLAY_DEF), .BUILTIN_ACK_LAT(ACK_DEF)) dut (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp), .load_req_in(load_req),
        .irq_event_in(irq_event), .msg_wr_out(msg_wr), .msg_wr_ready_in(msg_ready),
        .legacy_irq_out(legacy_irq), .replay_timeout_out(replay_to), .ack_latency_out(ack_lat),
        .range_decode_en_out(range_en), .pm_cap_disable_out(pm_dis), .msg_cap_disable_out(msg_dis));
    scr_msg_sink u_sink (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .msg_wr_in(msg_wr),
        .stall_in(4'h3), .ready_out(msg_ready), .taken_out(taken));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk_in) cfg_req <= '{1'b1, w, a, be, d};
        @(posedge core_clk_in) cfg_req.valid <= 1'b0;
        #1 rd = cfg_rsp.rdata;
        `CHK("ack", 1'b1, cfg_rsp.ack)
    endtask
    task automatic ld(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk_in) load_req <= '{1'b1, a, be, d};
        @(posedge core_clk_in) load_req.valid <= 1'b0;
        #1;
    endtask
    task automatic do_reset();
        @(posedge core_clk_in) rstn_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        rstn_in <= 1'b1;
    endtask
    task automatic pulse_irq();
        @(posedge core_clk_in) irq_event <= 1'b1;
        @(posedge core_clk_in) irq_event <= 1'b0;
        #1;
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        conclude();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        do_reset();
        foreach (rows[i]) begin
            cfg(1'b0, rows[i].addr, 4'hF, 32'h0);
            `CHK("reset read", rows[i].rst, rd)
            cfg(1'b1, rows[i].addr, 4'hF, 32'hFFFFFFFF);
            cfg(1'b0, rows[i].addr, 4'hF, 32'h0);
            `CHK("ones read", rows[i].ones, rd)
        end
        `CHK("replay user", 12'hFFF, replay_to)
        `CHK("ack user", 14'h3FFF, ack_lat)
        cfg(1'b1, 8'h68, 4'h2, 32'h0);
        cfg(1'b0, 8'h68, 4'hF, 32'h0);
        `CHK("byte enable", 32'hFFFF00FF, rd)
        cfg(1'b1, 8'h70, 4'hF, 32'h40000ABC);
        `CHK("replay builtin", REPLAY_DEF, replay_to)
        `CHK("ack zero", 14'h0000, ack_lat)
        cfg(1'b0, 8'h70, 4'hF, 32'h0);
        `CHK("timer read", 32'hC0000ABC, rd)
        ld(8'h44, 4'h8, 32'hAB000000);
        ld(8'h70, 4'h2, 32'h00006000);
        ld(8'h64, 4'hF, 32'h0);
        `CHK("pm disable", 1'b1, pm_dis)
        `CHK("msg disable", 1'b1, msg_dis)
        cfg(1'b0, 8'h44, 4'hF, 32'h0);
        `CHK("loaded data", 32'hAB000000, rd)
        cfg(1'b0, 8'h64, 4'hF, 32'h0);
        `CHK("fixed vendor", 32'h0034B009, rd)
        cfg(1'b1, 8'h50, 4'hF, 32'h1234567B);
        cfg(1'b1, 8'h54, 4'hF, 32'hCAFE0001);
        cfg(1'b1, 8'h58, 4'hF, 32'hFFFFBEEF);
        pulse_irq();
        `CHK("no legacy", 1'b0, legacy_irq)
        `CHK("early valid", 1'b0, msg_wr.valid)
        @(posedge core_clk_in) #1;
        `CHK("msg valid", 1'b1, msg_wr.valid)
        `CHK("msg addr", 64'hCAFE000112345678, msg_wr.addr)
        `CHK("msg data", 16'hBEEF, msg_wr.data)
        for (int n = 0; n < 20 && msg_wr.valid === 1'b1; n++) @(posedge core_clk_in) #1;
        `CHK("msg taken", 8'h01, taken)
        cfg(1'b1, 8'h4C, 4'h4, 32'h0);
        pulse_irq();
        `CHK("legacy pulse", 1'b1, legacy_irq)
        @(posedge core_clk_in) #1;
        `CHK("legacy end", 1'b0, legacy_irq)
        `CHK("no msg", 1'b0, msg_wr.valid)
        cfg(1'b1, 8'h4C, 4'h4, 32'h00010000);
        @(posedge core_clk_in) irq_event <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        irq_event <= 1'b0;
        for (int n = 0; n < 40 && taken !== 8'h03; n++) @(posedge core_clk_in) #1;
        `CHK("set wins", 8'h03, taken)
        @(posedge core_clk_in) begin
            cfg_req <= '{1'b1, 1'b1, 8'h6C, 4'hF, 32'h11111111};
            load_req <= '{1'b1, 8'h6C, 4'hF, 32'h22222222};
        end
        @(posedge core_clk_in) begin
            cfg_req.valid <= 1'b0;
            load_req.valid <= 1'b0;
        end
        cfg(1'b0, 8'h6C, 4'hF, 32'h0);
        `CHK("load wins", 32'h22222222, rd)
        do_reset();
        foreach (rows[i]) begin
            cfg(1'b0, rows[i].addr, 4'hF, 32'h0);
            `CHK("rerun reset", rows[i].rst, rd)
        end
        `CHK("replay reset", REPLAY_DEF, replay_to)
        `CHK("ack reset", ACK_DEF, ack_lat)
        `CHK("pm reset", 1'b0, pm_dis)
        `CHK("msg dis reset", 1'b0, msg_dis)
        `CHK("range out", 1'b1, range_en)
        conclude();
    end
endmodule // tb_top
bind scr_cfg_regs scr_cfg_props #(.BUILTIN_REPLAY(BUILTIN_REPLAY), .BUILTIN_ACK_LAT(BUILTIN_ACK_LAT)) u_props (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .cfg_req_in(cfg_req_in), .cfg_rsp_out(cfg_rsp_out),
    .load_req_in(load_req_in), .irq_event_in(irq_event_in), .msg_wr_out(msg_wr_out),
    .msg_wr_ready_in(msg_wr_ready_in), .legacy_irq_out(legacy_irq_out), .replay_timeout_out(replay_timeout_out),
    .ack_latency_out(ack_latency_out), .range_decode_en_out(range_decode_en_out));
